// >>> src/smma_top.sv
// SPI slave front end giving the host byte access to the memory map

// Functional notes
// - Clock idles high; out falling, in rising
// - Three command bytes: address low and direction, address high, count
// - First byte bit zero: 0 write, 1 read
// - Address: byte0 bits 7..1, byte1 high
// - Third byte is data byte count
// - Write data stored at incrementing addresses
// - Read data returned from incrementing addresses
// - Answer 0x55 during command bytes
// - Answer 0xAA during write data
// - Answer 0xEE after count is exhausted
// - Read-only write: discard rest, answer 0xEE
// - Message pin low while message pending
module smma_top #(
  parameter int GAP_RD_CYCLES = smma_pkg::GAP_RD_CYC,
  parameter int GAP_WR_CYCLES = smma_pkg::GAP_WR_CYC
) (
  // System clock and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  // Serial link from the host
  input wire logic sck_i,
  input wire logic ss_n_i,
  input wire logic mosi_i,
  output logic miso_o,
  output logic miso_oe_o,
  // Open-drain message waiting pin
  input wire logic change_i,
  output logic change_o,
  output logic change_oe_o,
  // Message handler
  input wire logic msg_pending_i,
  input wire logic [smma_pkg::ADDR_W-1:0] msg_addr_i,
  output logic msg_taken_o,
  // Memory map port
  output logic mem_req_valid_o,
  output smma_pkg::smma_mem_req_t mem_req_o,
  input wire logic mem_rsp_valid_i,
  input wire smma_pkg::smma_mem_rsp_t mem_rsp_i,
  // Status
  output smma_pkg::smma_status_t status_o
);
  import smma_pkg::*;

  localparam int GAP_MAX = (GAP_WR_CYCLES > GAP_RD_CYCLES) ? GAP_WR_CYCLES : GAP_RD_CYCLES;
  localparam int GAP_W = $clog2(GAP_MAX + 1);
  localparam logic [GAP_W-1:0] GAP_SAT = '1;
  localparam logic [GAP_W-1:0] GAP_RD_LIM = GAP_W'(GAP_RD_CYCLES);
  localparam logic [GAP_W-1:0] GAP_WR_LIM = GAP_W'(GAP_WR_CYCLES);

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR_LO,
    ST_ADDR_HI,
    ST_COUNT,
    ST_DATA,
    ST_FETCH,
    ST_STORE,
    ST_OVER
  } smma_xstate_t;

  typedef enum logic [1:0] {
    CH_IDLE,
    CH_LOW,
    CH_RELEASE
  } smma_chstate_t;

  function automatic logic [ADDR_W-1:0] addr_inc(input logic [ADDR_W-1:0] a);
    return a + 1'b1;
  endfunction

  logic [2:0] sync_meta;
  logic [2:0] sync_q;
  logic ss_high;
  logic tog_now;
  logic chg_high;
  logic ss_prev;
  logic tog_prev;
  logic ss_rise;
  logic ss_fall;
  logic rx_evt;
  logic rx_toggle;
  logic [DATA_W-1:0] rx_byte;
  smma_xstate_t state;
  smma_chstate_t ch_state;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] remain;
  logic [DATA_W-1:0] tx_byte;
  logic is_read;
  logic err;
  logic msg_hit;
  logic [GAP_W-1:0] gap_cnt;
  logic last_wr;
  logic gap_viol;

  // ************************************************************
  // Link side shifter
  // ************************************************************
  smma_link u_link (
    .reset_i(reset_i),
    .sck_i(sck_i),
    .ss_n_i(ss_n_i),
    .mosi_i(mosi_i),
    .miso_o(miso_o),
    .miso_oe_o(miso_oe_o),
    .tx_byte_i(tx_byte),
    .rx_byte_o(rx_byte),
    .rx_toggle_o(rx_toggle)
  );

  // ************************************************************
  // Crossings into the system clock
  // ************************************************************
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      sync_meta <= SYNC_RESET;
      sync_q <= SYNC_RESET;
    end else begin
      sync_meta <= {change_i, rx_toggle, ss_n_i};
      sync_q <= sync_meta;
    end
  end

  assign ss_high = sync_q[0];
  assign tog_now = sync_q[1];
  assign chg_high = sync_q[2];

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      ss_prev <= 1'b1;
      tog_prev <= 1'b0;
    end else begin
      ss_prev <= ss_high;
      tog_prev <= tog_now;
    end
  end

  assign ss_rise = ss_high & ~ss_prev;
  assign ss_fall = ~ss_high & ss_prev;
  // Received byte is stable long before its toggle arrives here
  assign rx_evt = tog_now ^ tog_prev;

  // ************************************************************
  // Exchange sequencer
  // ************************************************************
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      state <= ST_IDLE;
      addr <= '0;
      remain <= '0;
      is_read <= 1'b0;
      err <= 1'b0;
      msg_hit <= 1'b0;
      tx_byte <= MISO_CMD;
      mem_req_valid_o <= 1'b0;
      mem_req_o <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          addr <= '0;
          remain <= '0;
          err <= 1'b0;
          msg_hit <= 1'b0;
          tx_byte <= MISO_CMD;
          if (!ss_high) begin
            state <= ST_ADDR_LO;
          end
        end
        ST_ADDR_LO: begin
          if (ss_high) begin
            state <= ST_IDLE;
          end else if (rx_evt) begin
            is_read <= rx_byte[DIR_BIT];
            addr[ADDR_LO_W-1:0] <= rx_byte[DATA_W-1:ADDR_LO_LSB];
            state <= ST_ADDR_HI;
          end
        end
        ST_ADDR_HI: begin
          if (ss_high) begin
            state <= ST_IDLE;
          end else if (rx_evt) begin
            addr[ADDR_W-1:ADDR_LO_W] <= rx_byte;
            state <= ST_COUNT;
          end
        end
        ST_COUNT: begin
          if (ss_high) begin
            state <= ST_IDLE;
          end else if (rx_evt) begin
            remain <= rx_byte;
            if (rx_byte == '0) begin
              tx_byte <= MISO_ERR;
              state <= ST_OVER;
            end else if (is_read) begin
              mem_req_valid_o <= 1'b1;
              mem_req_o <= '{we: 1'b0, addr: addr, wdata: '0};
              state <= ST_FETCH;
            end else begin
              tx_byte <= MISO_WR;
              state <= ST_DATA;
            end
          end
        end
        ST_DATA: begin
          if (ss_high) begin
            state <= ST_IDLE;
          end else if (rx_evt) begin
            remain <= remain - 1'b1;
            if (is_read) begin
              // Byte from this address has now been clocked out
              if (addr == msg_addr_i) begin
                msg_hit <= 1'b1;
              end
              if (remain == 8'h01) begin
                tx_byte <= MISO_ERR;
                state <= ST_OVER;
              end else begin
                addr <= addr_inc(addr);
                mem_req_valid_o <= 1'b1;
                mem_req_o <= '{we: 1'b0, addr: addr_inc(addr), wdata: '0};
                state <= ST_FETCH;
              end
            end else if (err) begin
              addr <= addr_inc(addr);
              tx_byte <= MISO_ERR;
              if (remain == 8'h01) begin
                state <= ST_OVER;
              end
            end else begin
              mem_req_valid_o <= 1'b1;
              mem_req_o <= '{we: 1'b1, addr: addr, wdata: rx_byte};
              state <= ST_STORE;
            end
          end
        end
        ST_FETCH: begin
          // Memory handshake always completes, even on an aborted frame
          if (mem_rsp_valid_i) begin
            mem_req_valid_o <= 1'b0;
            tx_byte <= mem_rsp_i.rdata;
            state <= ss_high ? ST_IDLE : ST_DATA;
          end
        end
        ST_STORE: begin
          if (mem_rsp_valid_i) begin
            mem_req_valid_o <= 1'b0;
            addr <= addr_inc(addr);
            if (mem_rsp_i.ro) begin
              err <= 1'b1;
            end
            if (mem_rsp_i.ro || remain == '0) begin
              tx_byte <= MISO_ERR;
            end else begin
              tx_byte <= MISO_WR;
            end
            if (ss_high) begin
              state <= ST_IDLE;
            end else if (remain == '0) begin
              state <= ST_OVER;
            end else begin
              state <= ST_DATA;
            end
          end
        end
        ST_OVER: begin
          tx_byte <= MISO_ERR;
          if (ss_high) begin
            state <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ************************************************************
  // Exchange gap monitor
  // ************************************************************
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      gap_cnt <= GAP_SAT;
      last_wr <= 1'b0;
      gap_viol <= 1'b0;
    end else begin
      if (ss_rise) begin
        // First high cycle counts, so a gap of exactly the limit is legal
        gap_cnt <= GAP_W'(1);
        last_wr <= ~is_read;
      end else if (ss_high && gap_cnt != GAP_SAT) begin
        gap_cnt <= gap_cnt + 1'b1;
      end
      if (ss_fall) begin
        gap_viol <= last_wr ? (gap_cnt < GAP_WR_LIM) : (gap_cnt < GAP_RD_LIM);
      end
    end
  end

  // ************************************************************
  // Message waiting pin
  // ************************************************************
  assign change_o = 1'b0;

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      ch_state <= CH_IDLE;
      change_oe_o <= 1'b0;
      msg_taken_o <= 1'b0;
    end else begin
      msg_taken_o <= 1'b0;
      case (ch_state)
        CH_IDLE: begin
          if (msg_pending_i) begin
            change_oe_o <= 1'b1;
            ch_state <= CH_LOW;
          end
        end
        CH_LOW: begin
          if (ss_rise && msg_hit) begin
            change_oe_o <= 1'b0;
            msg_taken_o <= 1'b1;
            ch_state <= CH_RELEASE;
          end
        end
        CH_RELEASE: begin
          // Wait for the released pin to read high before the next message
          if (chg_high) begin
            ch_state <= CH_IDLE;
          end
        end
        default: begin
          ch_state <= CH_IDLE;
        end
      endcase
    end
  end

  // ************************************************************
  // Status
  // ************************************************************
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      status_o <= '0;
    end else begin
      status_o.active <= ~ss_high;
      status_o.is_read <= is_read;
      status_o.error <= err;
      status_o.gap_viol <= gap_viol;
    end
  end

endmodule

// >>> src/smma_pkg.sv
// Shared constants and types for the SPI memory map access block
package smma_pkg;

  // ************************************************************
  // Widths
  // ************************************************************
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int BIT_CNT_W = 3;

  // ************************************************************
  // Command byte fields
  // ************************************************************
  localparam int DIR_BIT = 0;
  localparam int ADDR_LO_LSB = 1;
  localparam int ADDR_LO_W = 7;

  // ************************************************************
  // Fixed answer bytes
  // ************************************************************
  localparam logic [DATA_W-1:0] MISO_CMD = 8'h55;
  localparam logic [DATA_W-1:0] MISO_WR = 8'hAA;
  localparam logic [DATA_W-1:0] MISO_ERR = 8'hEE;

  // ************************************************************
  // Reset values
  // ************************************************************
  // Order is {message pin, receive toggle, select}
  localparam logic [2:0] SYNC_RESET = 3'h5;
  localparam logic MISO_RESET = 1'b1;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_SYS_HZ = 25_000_000;
  localparam int GAP_RD_MS = 2;
  localparam int GAP_WR_MS = 10;
  localparam int GAP_RD_CYC = GAP_RD_MS * (CLK_SYS_HZ / 1000);
  localparam int GAP_WR_CYC = GAP_WR_MS * (CLK_SYS_HZ / 1000);

  // ************************************************************
  // Carriers
  // ************************************************************
  typedef struct packed {
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } smma_mem_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] rdata;
    logic ro;
  } smma_mem_rsp_t;

  typedef struct packed {
    logic active;
    logic is_read;
    logic error;
    logic gap_viol;
  } smma_status_t;

endpackage

// >>> src/smma_link.sv
// Serial shifter running on the host's clock
module smma_link (
  // Reset
  input wire logic reset_i,
  // Serial pins
  input wire logic sck_i,
  input wire logic ss_n_i,
  input wire logic mosi_i,
  output logic miso_o,
  output logic miso_oe_o,
  // Byte exchange with system clock side
  input wire logic [smma_pkg::DATA_W-1:0] tx_byte_i,
  output logic [smma_pkg::DATA_W-1:0] rx_byte_o,
  output logic rx_toggle_o
);
  import smma_pkg::*;

  logic link_rst;
  logic [BIT_CNT_W-1:0] bit_cnt;
  logic [DATA_W-2:0] rx_sh;
  logic [DATA_W-2:0] tx_sh;

  // Select high clears the frame state at once
  assign link_rst = reset_i | ss_n_i;

  // ************************************************************
  // Receive on rising edges
  // ************************************************************
  always_ff @(posedge sck_i or posedge link_rst) begin
    if (link_rst) begin
      bit_cnt <= '0;
      rx_sh <= '0;
    end else begin
      bit_cnt <= bit_cnt + 1'b1;
      rx_sh <= {rx_sh[DATA_W-3:0], mosi_i};
    end
  end

  // Toggle survives select so the far side never sees a false event
  always_ff @(posedge sck_i or posedge reset_i) begin
    if (reset_i) begin
      rx_byte_o <= '0;
      rx_toggle_o <= 1'b0;
    end else if (bit_cnt == BIT_CNT_W'(DATA_W - 1)) begin
      rx_byte_o <= {rx_sh, mosi_i};
      rx_toggle_o <= ~rx_toggle_o;
    end
  end

  // ************************************************************
  // Transmit on falling edges
  // ************************************************************
  // Answer byte settles within the byte gap and is held stable until it is loaded
  always_ff @(negedge sck_i or posedge link_rst) begin
    if (link_rst) begin
      miso_o <= MISO_RESET;
      miso_oe_o <= 1'b0;
      tx_sh <= '0;
    end else begin
      miso_oe_o <= 1'b1;
      if (bit_cnt == '0) begin
        miso_o <= tx_byte_i[DATA_W-1];
        tx_sh <= tx_byte_i[DATA_W-2:0];
      end else begin
        miso_o <= tx_sh[DATA_W-2];
        tx_sh <= {tx_sh[DATA_W-3:0], 1'b0};
      end
    end
  end

endmodule

// >>> dv/smma_asserts.sv
// Concurrent checks on the ports of the SPI memory map access block
module smma_asserts (
  // Clocks and reset
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic sck_i,
  input wire logic ss_n_i,
  // Watched outputs and qualifiers
  input wire logic miso_oe_o,
  input wire logic change_o,
  input wire logic change_oe_o,
  input wire logic msg_pending_i,
  input wire logic msg_taken_o,
  input wire logic mem_req_valid_o,
  input wire smma_pkg::smma_mem_req_t mem_req_o,
  input wire logic mem_rsp_valid_i,
  input wire smma_pkg::smma_status_t status_o
);
  timeunit 1ns;
  timeprecision 1ns;
  import smma_pkg::*;
  // ****
  // Assertions
  // ****
  float_idle_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    ss_n_i && $past(ss_n_i) |-> !miso_oe_o) else $error("miso driven while deselected");
  drive_frame_a: assert property (@(posedge sck_i) disable iff (reset_i || ss_n_i)
    miso_oe_o) else $error("miso not driven at sample edge");
  req_hold_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    mem_req_valid_o && !mem_rsp_valid_i |=> mem_req_valid_o && $stable(mem_req_o))
    else $error("request dropped or changed early");
  req_drop_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    mem_req_valid_o && mem_rsp_valid_i |=> !mem_req_valid_o) else $error("request held");
  req_frame_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    $rose(mem_req_valid_o) |-> status_o.active) else $error("request outside frame");
  write_dir_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    $rose(mem_req_valid_o) |-> mem_req_o.we == !status_o.is_read)
    else $error("request direction mismatch");
  pin_low_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    !change_o) else $error("message pin driven high");
  msg_raise_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    $rose(change_oe_o) |-> $past(msg_pending_i)) else $error("pin pulled with no message");
  taken_rel_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    msg_taken_o |-> !change_oe_o && $past(change_oe_o) ##1 !msg_taken_o)
    else $error("message release wrong");
  // ****
  // Coverage
  // ****
  wr_req_c: cover property (@(posedge clk_sys_i) mem_req_valid_o && mem_req_o.we);
  rd_req_c: cover property (@(posedge clk_sys_i) mem_req_valid_o && !mem_req_o.we);
  taken_c: cover property (@(posedge clk_sys_i) msg_taken_o);
  error_c: cover property (@(posedge clk_sys_i) status_o.error);
endmodule

// >>> dv/smma_host.sv
// Host-side SPI master model driving the serial link
module smma_host (
  // Serial pins
  output logic sck_o,
  output logic ss_n_o,
  output logic mosi_o,
  input wire logic miso_i
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int HALF_NS = 80;
  localparam int BYTE_GAP_NS = 100_000;
  initial begin
    sck_o = 1'b1;
    ss_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  // ****
  // Frame control
  // ****
  task automatic start_frame();
    ss_n_o = 1'b0;
    // Odd offset keeps the link clock out of step with the system clock
    #2_007;
  endtask
  task automatic end_frame(input int gap_ns);
    #20_000;
    ss_n_o = 1'b1;
    mosi_o = ~mosi_o;
    #(gap_ns);
  endtask
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, input int bits);
    rx = 8'h00;
    for (int i = 7; i > 7 - bits; i--) begin
      sck_o = 1'b0;
      mosi_o = tx[i];
      #HALF_NS;
      sck_o = 1'b1;
      rx[i] = miso_i;
      #HALF_NS;
    end
    #BYTE_GAP_NS;
  endtask
endmodule

// >>> dv/smma_top_bench.sv
// Self-checking bench for the SPI memory map access block
module smma_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import smma_pkg::*;
  localparam int GAP_RD = 50;
  localparam int GAP_WR = 250;
  localparam logic [14:0] RO_BASE = 15'h7F00;
  logic clk_sys, reset, sck, ss_n, mosi, miso, miso_w, miso_oe, change_w, change_o, change_oe;
  logic msg_pending, msg_taken, mem_req_valid, mem_rsp_valid;
  logic [14:0] msg_addr, last_addr;
  smma_mem_req_t mem_req;
  smma_mem_rsp_t mem_rsp;
  smma_status_t status;
  logic [7:0] mem [256];
  int wr_cnt, mem_lat, lat_cnt, miscompares, num_checks;
  assign change_w = change_oe ? change_o : 1'b1;
  // Released data line shows the inverse so a late drive is caught
  assign miso_w = miso_oe ? miso : ~miso;
  smma_top #(.GAP_RD_CYCLES(GAP_RD), .GAP_WR_CYCLES(GAP_WR)) dut_u (.clk_sys_i(clk_sys),
    .reset_i(reset), .sck_i(sck), .ss_n_i(ss_n), .mosi_i(mosi), .miso_o(miso),
    .miso_oe_o(miso_oe), .change_i(change_w), .change_o(change_o), .change_oe_o(change_oe),
    .msg_pending_i(msg_pending), .msg_addr_i(msg_addr), .msg_taken_o(msg_taken),
    .mem_req_valid_o(mem_req_valid), .mem_req_o(mem_req), .mem_rsp_valid_i(mem_rsp_valid),
    .mem_rsp_i(mem_rsp), .status_o(status));
  smma_host host_u (.sck_o(sck), .ss_n_o(ss_n), .mosi_o(mosi), .miso_i(miso_w));
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // ****
  // Memory and message handler models
  // ****
  always @(negedge clk_sys) begin
    mem_rsp_valid <= 1'b0;
    if (msg_taken) msg_pending <= 1'b0;
    if (!mem_req_valid || mem_rsp_valid) lat_cnt <= 0;
    else if (lat_cnt < mem_lat) lat_cnt <= lat_cnt + 1;
    else begin
      mem_rsp_valid <= 1'b1;
      last_addr <= mem_req.addr;
      mem_rsp.ro <= mem_req.addr >= RO_BASE;
      mem_rsp.rdata <= mem[mem_req.addr[7:0]];
      if (mem_req.we) wr_cnt <= wr_cnt + 1;
      if (mem_req.we && mem_req.addr < RO_BASE) mem[mem_req.addr[7:0]] <= mem_req.wdata;
    end
  end
  // ****
  // Shared tasks
  // ****
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask
  task automatic run_frame(input logic [7:0] tx[6], input logic [7:0] exp[6], input int n,
                           input int gap);
    logic [7:0] rx;
    host_u.start_frame();
    for (int i = 0; i < n; i++) begin
      host_u.xfer(tx[i], rx, 8);
      check(rx, exp[i], "miso byte");
      check(miso_oe, 1'b1, "miso drive");
      check(status.active, 1'b1, "frame seen");
    end
    host_u.end_frame(gap);
    check(miso_oe, 1'b0, "miso float");
    check(status.active, 1'b0, "frame closed");
  endtask
  task automatic summarize();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ****
  // Scenarios
  // ****
  task automatic write_test();
    mem_lat = 0;
    run_frame('{8'h24, 8'h00, 8'h02, 8'hA5, 8'h3C, 8'h77},
              '{8'h55, 8'h55, 8'h55, 8'hAA, 8'hAA, 8'hEE}, 6, GAP_WR * 40);
    check(mem[8'h12], 8'hA5, "first write");
    check(mem[8'h13], 8'h3C, "second write");
    check(wr_cnt, 2, "write count");
    check(status.is_read, 1'b0, "write dir");
  endtask
  task automatic read_msg_test();
    mem_lat = 20;
    @(negedge clk_sys);
    msg_addr = 15'h0013;
    msg_pending = 1'b1;
    repeat (3) @(negedge clk_sys);
    check(change_w, 1'b0, "pin pulled");
    run_frame('{8'h25, 8'h00, 8'h02, 8'hFF, 8'hFF, 8'hFF},
              '{8'h55, 8'h55, 8'h55, 8'hA5, 8'h3C, 8'hEE}, 6, GAP_RD * 40);
    check(status.is_read, 1'b1, "read dir");
    check(status.gap_viol, 1'b0, "write gap");
    check(change_oe, 1'b0, "pin released");
    check(msg_pending, 1'b0, "message taken");
  endtask
  task automatic ro_test();
    int w0;
    mem_lat = 0;
    w0 = wr_cnt;
    run_frame('{8'h00, 8'hFE, 8'h02, 8'h11, 8'h22, 8'h33},
              '{8'h55, 8'h55, 8'h55, 8'hAA, 8'hEE, 8'hEE}, 6, 400);
    check(wr_cnt - w0, 1, "refused writes");
    check(last_addr, RO_BASE, "high address");
    check(status.is_read, 1'b0, "ro dir");
  endtask
  task automatic zero_abort_test();
    logic [7:0] rx;
    run_frame('{8'h25, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00},
              '{8'h55, 8'h55, 8'h55, 8'hEE, 8'h00, 8'h00}, 4, GAP_RD * 40);
    check(status.gap_viol, 1'b1, "short gap");
    host_u.start_frame();
    host_u.xfer(8'h24, rx, 4);
    check(rx, 8'h50, "cut byte");
    host_u.end_frame(GAP_WR * 40);
    check(status.gap_viol, 1'b0, "exact gap");
    run_frame('{8'h25, 8'h00, 8'h01, 8'hFF, 8'h00, 8'h00},
              '{8'h55, 8'h55, 8'h55, 8'hA5, 8'h00, 8'h00}, 4, GAP_RD * 40);
    check(status.gap_viol, 1'b0, "gap kept");
  endtask
  // ****
  // Main sequence and watchdog
  // ****
  initial begin
    reset = 1'b1;
    msg_pending = 1'b0;
    msg_addr = 15'h0000;
    mem_rsp_valid = 1'b0;
    mem_rsp = '0;
    wr_cnt = 0;
    mem_lat = 0;
    foreach (mem[i]) mem[i] = 8'h00;
    repeat (2) @(negedge clk_sys);
    reset = 1'b0;
    repeat (4) @(negedge clk_sys);
    write_test();
    read_msg_test();
    ro_test();
    zero_abort_test();
    summarize();
  end
  initial begin
    #3_600_000;
    miscompares++;
    summarize();
  end
endmodule
bind smma_top smma_asserts chk_u (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .sck_i(sck_i),
  .ss_n_i(ss_n_i), .miso_oe_o(miso_oe_o), .change_o(change_o), .change_oe_o(change_oe_o),
  .msg_pending_i(msg_pending_i), .msg_taken_o(msg_taken_o),
  .mem_req_valid_o(mem_req_valid_o), .mem_req_o(mem_req_o),
  .mem_rsp_valid_i(mem_rsp_valid_i), .status_o(status_o));
